// ===== logic/gpt_pkg.sv
// Package: register map, field positions and constants for the 16-bit timer
package gpt_pkg;
	// ==========================================================
	// Register offsets (word index on the plain register port)
	localparam logic [2:0] OFS_CONTROL    = 3'h0;
	localparam logic [2:0] OFS_PERIOD     = 3'h1;
	localparam logic [2:0] OFS_COUNT      = 3'h2;
	localparam logic [2:0] OFS_IRQ_STATUS = 3'h3;
	localparam logic [2:0] OFS_IRQ_ENABLE = 3'h4;
	localparam logic [2:0] OFS_IRQ_CLEAR  = 3'h5;
	// ==========================================================
	// Control register field positions
	localparam int BIT_RUN_ENABLE = 15;
	localparam int BIT_IDLE_HALT  = 13;
	localparam int BIT_GATE_EN    = 6;
	localparam int BIT_PRESC_HI   = 5;
	localparam int BIT_PRESC_LO   = 4;
	localparam int BIT_EXT_SYNC   = 2;
	localparam int BIT_SRC_SEL    = 1;
	// Writable bits of the control register
	localparam logic [15:0] CONTROL_MASK  = 16'ha076;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET  = 16'hffff;
	// ==========================================================
	// Interrupt status bits
	localparam int IRQ_BIT_MATCH = 0;
	localparam int IRQ_BIT_GATE  = 1;
	// Prescale terminal counts (ratio minus one)
	localparam logic [7:0] PRESC_DIV1   = 8'h00;
	localparam logic [7:0] PRESC_DIV8   = 8'h07;
	localparam logic [7:0] PRESC_DIV64  = 8'h3f;
	localparam logic [7:0] PRESC_DIV256 = 8'hff;
endpackage : gpt_pkg

// ===== logic/gpt_timer.sv
// Gated, prescaled 16-bit timer/counter with register port and interrupt
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
// ==========================================================
// Contract
// [RULE_01] A 16-bit counter serving as interval timer or real-time base.
// [RULE_02] Modes: timer, synchronous counter, asynchronous external counter.
// [RULE_03] Interrupt on period match or on gate falling edge.
// [RULE_04] Keeps counting in idle and sleep unless told otherwise; sleep here stops all but the async counter.
// [RULE_05] Control bit 15 starts the counter when set, stops when clear.
// [RULE_06] Control bit 13 halts the module while the device idles.
// [RULE_07] Control bit 6 enables gated accumulation, internal clock only.
// [RULE_08] Bits 5-4 prescale: 1:1, 1:8, 1:64, 1:256.
// [RULE_09] Bit 2 synchronises the external clock; ignored when internal.
// [RULE_10] Bit 1 picks external pin rising edge, else instruction clock.
// [RULE_11] Control bits 14, 12-7, 3 and 0 read as zero.
// [RULE_12] Software sets prescale, source, gating, sync and period.
// [RULE_13] Software picks sync or async before external counting.
// [RULE_14] Software sets interrupt enable and priority when wanted.
// [RULE_15] On period match the count clears next tick and flag sets.
// [RULE_16] Gated mode counts while gate high; flags on gate falling edge.
// [RULE_17] All control bits reset to zero: stopped, internal, 1:1.
module gpt_timer
	import gpt_pkg::*;
#(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             reset,
	// Register port
	input  wire logic [2:0]       reg_addr,
	input  wire logic [15:0]      reg_wdata,
	input  wire logic             reg_write,
	input  wire logic             reg_read,
	output logic      [15:0]      reg_rdata,
	// Device power state
	input  wire logic             cpu_idle,
	input  wire logic             cpu_sleep,
	// Instruction-cycle clock tick and external pins
	input  wire logic             instruction_cycle_clock,
	input  wire logic             ext_count_clock_pin,
	input  wire logic             gate_pin,
	// Interrupt
	output logic                  timer_irq
);

	// ==========================================================
	// State
	logic [15:0]      control_r, control_nxt;
	logic [WIDTH-1:0] period_value_r, period_value_nxt;
	logic [WIDTH-1:0] count_r, count_nxt;
	logic [7:0]       presc_r, presc_nxt;
	logic [1:0]       irq_status_r, irq_status_nxt;
	logic [1:0]       timer_irq_enable_r, timer_irq_enable_nxt;
	logic [15:0]      reg_rdata_r, reg_rdata_nxt;
	logic             timer_irq_r, timer_irq_nxt;
	logic             ext_s1_r, ext_s2_r, ext_s3_r;
	logic             ext_s1_nxt, ext_s2_nxt, ext_s3_nxt;
	logic             ext_raw_r, ext_raw_nxt;
	logic             gate_d_r, gate_d_nxt;

	// Decoded control fields
	logic       run_enable, idle_halt, gated_accumulate_enable;
	logic       ext_clock_sync_select, count_source_select;
	logic [1:0] prescale_select;
	logic       ext_edge, src_tick, presc_tick, gate_fall, match;
	logic       active;
	logic [7:0] presc_term;

	// Terminal prescale count for the selected ratio
	function automatic logic [7:0] presc_limit(input logic [1:0] sel);
		unique case (sel)
			2'b00: presc_limit = PRESC_DIV1;
			2'b01: presc_limit = PRESC_DIV8;
			2'b10: presc_limit = PRESC_DIV64;
			2'b11: presc_limit = PRESC_DIV256;
		endcase
	endfunction : presc_limit

	assign run_enable              = control_r[BIT_RUN_ENABLE];
	assign idle_halt               = control_r[BIT_IDLE_HALT];
	assign gated_accumulate_enable = control_r[BIT_GATE_EN];
	assign prescale_select         = control_r[BIT_PRESC_HI:BIT_PRESC_LO];
	assign ext_clock_sync_select   = control_r[BIT_EXT_SYNC];
	assign count_source_select     = control_r[BIT_SRC_SEL];

	// ==========================================================
	// External clock edge detection; the first stage feeds only the second
	always_comb begin
		ext_s1_nxt  = ext_count_clock_pin;
		ext_s2_nxt  = ext_s1_r;
		ext_s3_nxt  = ext_s2_r;
		ext_raw_nxt = ext_count_clock_pin;
		gate_d_nxt  = gate_pin;
	end

	// Register the pin samples
	always_ff @(posedge clock) begin
		if (reset) begin
			ext_s1_r  <= 1'b0;
			ext_s2_r  <= 1'b0;
			ext_s3_r  <= 1'b0;
			ext_raw_r <= 1'b0;
			gate_d_r  <= 1'b0;
		end else begin
			ext_s1_r  <= ext_s1_nxt;
			ext_s2_r  <= ext_s2_nxt;
			ext_s3_r  <= ext_s3_nxt;
			ext_raw_r <= ext_raw_nxt;
			gate_d_r  <= gate_d_nxt;
		end
	end

	// Unsynchronised path trades two cycles of latency for glitch risk
	always_comb begin
		if (ext_clock_sync_select) // RULE_09
			ext_edge = ext_s2_r & ~ext_s3_r;
		else
			ext_edge = ext_count_clock_pin & ~ext_raw_r;
	end

	// Sleep stops the instruction clock; only the async counter runs on
	assign active = run_enable // RULE_05
		& ~(cpu_idle & idle_halt) // RULE_06
		& ~(cpu_sleep & (~count_source_select | ext_clock_sync_select)); // RULE_04
	// Source selection and gating
	assign src_tick = count_source_select ? ext_edge // RULE_10
		: (instruction_cycle_clock
		& (~gated_accumulate_enable | gate_pin)); // RULE_07 RULE_16
	assign presc_term = presc_limit(prescale_select); // RULE_08
	assign presc_tick = active & src_tick & (presc_r == presc_term);
	assign gate_fall  = gate_d_r & ~gate_pin & ~count_source_select
		& gated_accumulate_enable & active;
	assign match      = (count_r == period_value_r);

	// ==========================================================
	// Next-state for counter, prescaler and flags
	always_comb begin
		count_nxt            = count_r;
		presc_nxt            = presc_r;
		irq_status_nxt       = irq_status_r;
		control_nxt          = control_r;
		period_value_nxt     = period_value_r;
		timer_irq_enable_nxt = timer_irq_enable_r;
		reg_rdata_nxt        = 16'h0000;
		if (active & src_tick)
			presc_nxt = (presc_r == presc_term) ? 8'h00 : presc_r + 8'h01;
		if (presc_tick) begin
			if (match) // RULE_15
				count_nxt = '0;
			else
				count_nxt = count_r + WIDTH'(1); // RULE_01 RULE_02
		end
		// Register writes
		if (reg_write) begin
			unique case (reg_addr)
				OFS_CONTROL:    control_nxt = reg_wdata & CONTROL_MASK; // RULE_11
				OFS_PERIOD:     period_value_nxt = reg_wdata[WIDTH-1:0];
				OFS_COUNT:      count_nxt = reg_wdata[WIDTH-1:0];
				OFS_IRQ_ENABLE: timer_irq_enable_nxt = reg_wdata[1:0];
				OFS_IRQ_CLEAR:  irq_status_nxt = irq_status_r & ~reg_wdata[1:0];
				default:        ;
			endcase
		end
		// Hardware set wins over a simultaneous software clear
		if (presc_tick & match & ~(gated_accumulate_enable
			& ~count_source_select)) // RULE_03 RULE_15
			irq_status_nxt[IRQ_BIT_MATCH] = 1'b1;
		if (gate_fall) // RULE_03 RULE_16
			irq_status_nxt[IRQ_BIT_GATE] = 1'b1;
		// A control write restarts the prescaler, so a new ratio never
		// meets a stale count above its terminal value
		if (!run_enable || (reg_write && reg_addr == OFS_CONTROL))
			presc_nxt = 8'h00;
		// Read data, one cycle after the strobe
		if (reg_read) begin
			unique case (reg_addr)
				OFS_CONTROL:    reg_rdata_nxt = control_r; // RULE_11
				OFS_PERIOD:     reg_rdata_nxt = 16'(period_value_r);
				OFS_COUNT:      reg_rdata_nxt = 16'(count_r);
				OFS_IRQ_STATUS: reg_rdata_nxt = {14'h0000, irq_status_r};
				OFS_IRQ_ENABLE: reg_rdata_nxt = {14'h0000, timer_irq_enable_r};
				default:        reg_rdata_nxt = 16'h0000;
			endcase
		end
		timer_irq_nxt = |(irq_status_nxt & timer_irq_enable_nxt);
	end

	// Register all state
	always_ff @(posedge clock) begin
		if (reset) begin
			control_r          <= CONTROL_RESET; // RULE_17
			period_value_r     <= PERIOD_RESET;
			count_r            <= '0;
			presc_r            <= 8'h00;
			irq_status_r       <= 2'b00;
			timer_irq_enable_r <= 2'b00;
			reg_rdata_r        <= 16'h0000;
			timer_irq_r        <= 1'b0;
		end else begin
			control_r          <= control_nxt;
			period_value_r     <= period_value_nxt;
			count_r            <= count_nxt;
			presc_r            <= presc_nxt;
			irq_status_r       <= irq_status_nxt;
			timer_irq_enable_r <= timer_irq_enable_nxt;
			reg_rdata_r        <= reg_rdata_nxt;
			timer_irq_r        <= timer_irq_nxt;
		end
	end

	assign reg_rdata = reg_rdata_r;
	assign timer_irq = timer_irq_r;

	// ==========================================================
	// Assertions: one clock domain, so clock and reset are given once
	default clocking gpt_cb @(posedge clock);
	endclocking
	default disable iff (reset);

	// Counting and halting; a count write overrides a tick, hence the guards
	AST_STOPPED_HOLDS: assert property ( // RULE_05
		(!run_enable && !reg_write) |=> $stable(count_r))
		else $error("Count moved while stopped");
	AST_PRESC_STOPPED: assert property ( // RULE_05
		!run_enable |=> presc_r == 8'h00)
		else $error("Prescaler not cleared while stopped");
	AST_COUNT_STEP: assert property ( // RULE_01
		(presc_tick && !match && !reg_write)
		|=> count_r == $past(count_r) + WIDTH'(1))
		else $error("Count did not advance by one on a tick");
	AST_MATCH_CLEARS: assert property ( // RULE_15
		(presc_tick && match && !reg_write) |=> count_r == '0)
		else $error("Count not cleared after period match");
	AST_IDLE_HALT: assert property ( // RULE_06
		(cpu_idle && idle_halt && !reg_write) |=> $stable(count_r))
		else $error("Count moved in idle with halt set");
	// Sleep freezes everything but the unsynchronised external count
	AST_SLEEP_HALT: assert property ( // RULE_04
		(cpu_sleep && (!count_source_select || ext_clock_sync_select)
		&& !reg_write) |=> $stable(count_r))
		else $error("Count moved in sleep on a stopped source");
	AST_GATE_LOW: assert property ( // RULE_07
		(gated_accumulate_enable && !count_source_select && !gate_pin
		&& !reg_write) |=> $stable(count_r))
		else $error("Count moved with gate low");
	AST_PRESC_RANGE: assert property ( // RULE_08
		presc_r <= presc_term || !$stable(prescale_select))
		else $error("Prescaler beyond terminal count");

	// Source selection: one count per detected pin edge at 1:1
	AST_EXT_SYNC: assert property ( // RULE_09
		(active && count_source_select && ext_clock_sync_select
		&& prescale_select == 2'b00 && presc_r == PRESC_DIV1
		&& ext_s2_r && !ext_s3_r && !match && !reg_write)
		|=> count_r == $past(count_r) + WIDTH'(1))
		else $error("Synchronised external edge not counted");
	AST_EXT_ASYNC: assert property ( // RULE_10
		(active && count_source_select && !ext_clock_sync_select
		&& prescale_select == 2'b00 && presc_r == PRESC_DIV1
		&& ext_count_clock_pin && !ext_raw_r && !match && !reg_write)
		|=> count_r == $past(count_r) + WIDTH'(1))
		else $error("Unsynchronised external edge not counted");

	// ==========================================================
	// Assertions: flags, interrupt and reset state
	AST_MATCH_FLAG: assert property ( // RULE_03
		(presc_tick && match
		&& !(gated_accumulate_enable && !count_source_select))
		|=> irq_status_r[IRQ_BIT_MATCH])
		else $error("Match flag not set");
	AST_GATE_FLAG: assert property ( // RULE_16
		gate_fall |=> irq_status_r[IRQ_BIT_GATE])
		else $error("Gate fall flag not set");
	// Flags rise only on their own events
	AST_MATCH_ONLY: assert property ( // RULE_15
		(!irq_status_r[IRQ_BIT_MATCH] && !(presc_tick && match))
		|=> !irq_status_r[IRQ_BIT_MATCH])
		else $error("Match flag set without a match");
	AST_GATE_ONLY: assert property ( // RULE_16
		(!irq_status_r[IRQ_BIT_GATE] && !gate_fall)
		|=> !irq_status_r[IRQ_BIT_GATE])
		else $error("Gate flag set without a falling gate");
	AST_IRQ_CLEAR: assert property ( // RULE_03
		(reg_write && reg_addr == OFS_IRQ_CLEAR
		&& reg_wdata[IRQ_BIT_MATCH] && !(presc_tick && match))
		|=> !irq_status_r[IRQ_BIT_MATCH])
		else $error("Match flag survived a clear");
	AST_IRQ_LEVEL: assert property ( // RULE_03
		timer_irq_r == |(irq_status_r & timer_irq_enable_r))
		else $error("Interrupt output disagrees with status");
	AST_RESERVED_ZERO: assert property ( // RULE_11
		(control_r & ~CONTROL_MASK) == 16'h0000)
		else $error("Unimplemented control bit set");
	// Checked on the first edge out of reset, before any write lands
	AST_RESET_STATE: assert property ( // RULE_17
		$fell(reset) |-> (control_r == CONTROL_RESET && count_r == '0))
		else $error("Control or count not cleared by reset");

	// ==========================================================
	// Coverage of the main scenarios
	COV_MATCH: cover property (@(posedge clock) presc_tick && match);
	COV_GATE: cover property (@(posedge clock) gate_fall);
	COV_EXT: cover property (@(posedge clock) count_source_select && presc_tick);
	COV_IRQ: cover property (@(posedge clock) $rose(timer_irq_r));
	COV_SLEEP: cover property (@(posedge clock) cpu_sleep && presc_tick);

endmodule : gpt_timer

// ===== verif/gpt_pin_model.sv
// Pin-side model: external count clock and gate inputs of the timer
`timescale 1ns/1ps
// ==========================================================
// Model
module gpt_pin_model (
	// Clock
	input  wire logic clock,
	// Pins toward the timer
	output logic      ext_count_clock_pin,
	output logic      gate_pin
);
	// Both pins rest low; the count clock stands still between bursts
	initial begin
		ext_count_clock_pin = 1'b0;
		gate_pin = 1'b0;
	end
	// Burst of n rising edges, slow enough for the synchroniser
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clock) ext_count_clock_pin <= 1'b1;
			repeat (4) @(posedge clock);
			ext_count_clock_pin <= 1'b0;
			repeat (3) @(posedge clock);
		end
	endtask : pulse
	// Gate level, changed just after an edge
	task automatic set_gate(input logic v);
		@(posedge clock) gate_pin <= v;
	endtask : set_gate
endmodule : gpt_pin_model

// ===== verif/tb_top.sv
// Self-checking bench for the gated prescaled timer
`timescale 1ns/1ps
module tb_top
	import gpt_pkg::*;
;
	// ==========================================================
	// Signals
	logic        clock, reset, reg_write, reg_read, cpu_idle, cpu_sleep;
	logic        icc, ext_count_clock_pin, gate_pin, timer_irq;
	logic [2:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	int          err_count, checks, cycles;

	gpt_timer dut_u (.clock(clock), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
		.instruction_cycle_clock(icc),
		.ext_count_clock_pin(ext_count_clock_pin), .gate_pin(gate_pin),
		.timer_irq(timer_irq));
	gpt_pin_model pin_u (.clock(clock),
		.ext_count_clock_pin(ext_count_clock_pin), .gate_pin(gate_pin));

	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Hang guard: whole run needs well under this many cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	// ==========================================================
	// Bus and comparison tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic chk(input logic [2:0] a, input logic [15:0] exp);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask : chk
	// Exactly n instruction-cycle ticks, then the source goes quiet
	task automatic ticks(input int n);
		@(posedge clock) icc <= 1'b1;
		repeat (n) @(posedge clock);
		icc <= 1'b0;
	endtask : ticks
	task automatic restart(input logic [15:0] ctl);
		wr(OFS_CONTROL, 16'h0000);
		wr(OFS_COUNT, 16'h0000);
		wr(OFS_IRQ_CLEAR, 16'h0003);
		wr(OFS_CONTROL, ctl);
	endtask : restart
	task report_and_stop;
		if (err_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		chk(OFS_CONTROL, 16'h0000);
		chk(OFS_PERIOD, 16'hffff);
		check({15'h0000, timer_irq}, 16'h0000);
		wr(OFS_CONTROL, 16'h5fff);
		chk(OFS_CONTROL, 16'h0076);
		wr(3'h6, 16'h1234);
		chk(3'h6, 16'h0000);
		chk(OFS_IRQ_CLEAR, 16'h0000);
	endtask : t_reset
	task automatic t_prescale;
		int r[4] = '{1, 8, 64, 256};
		for (int i = 0; i < 4; i++) begin
			restart(16'h8000 | (16'(i) << 4));
			ticks(5 * r[i]);
			chk(OFS_COUNT, 16'h0005);
		end
		wr(OFS_CONTROL, 16'h0000);
		ticks(4);
		chk(OFS_COUNT, 16'h0005);
	endtask : t_prescale
	task automatic t_match;
		wr(OFS_PERIOD, 16'h0002);
		wr(OFS_IRQ_ENABLE, 16'h0001);
		restart(16'h8000);
		ticks(3);
		chk(OFS_COUNT, 16'h0000);
		chk(OFS_IRQ_STATUS, 16'h0001);
		check({15'h0000, timer_irq}, 16'h0001);
		wr(OFS_IRQ_CLEAR, 16'h0001);
		chk(OFS_IRQ_STATUS, 16'h0000);
		check({15'h0000, timer_irq}, 16'h0000);
		wr(OFS_IRQ_ENABLE, 16'h0000);
		ticks(3);
		chk(OFS_IRQ_STATUS, 16'h0001);
		check({15'h0000, timer_irq}, 16'h0000);
		wr(OFS_PERIOD, 16'hffff);
	endtask : t_match
	task automatic t_gate;
		wr(OFS_IRQ_ENABLE, 16'h0002);
		restart(16'h8040);
		ticks(4);
		pin_u.set_gate(1'b1);
		ticks(6);
		pin_u.set_gate(1'b0);
		chk(OFS_COUNT, 16'h0006);
		chk(OFS_IRQ_STATUS, 16'h0002);
		check({15'h0000, timer_irq}, 16'h0001);
		chk(OFS_IRQ_ENABLE, 16'h0002);
	endtask : t_gate
	task automatic t_ext;
		logic [15:0] c[3] = '{16'h8042, 16'h8046, 16'h8002};
		for (int i = 0; i < 3; i++) begin
			cpu_sleep <= (i == 2);
			restart(c[i]);
			ticks(3);
			pin_u.pulse(4);
			repeat (8) @(posedge clock);
			chk(OFS_COUNT, 16'h0004);
		end
		cpu_sleep <= 1'b0;
	endtask : t_ext
	task automatic t_idle;
		cpu_idle <= 1'b1;
		restart(16'ha000);
		ticks(5);
		chk(OFS_COUNT, 16'h0000);
		wr(OFS_CONTROL, 16'h8000);
		ticks(5);
		chk(OFS_COUNT, 16'h0005);
		cpu_idle <= 1'b0;
		// Sleep stops the instruction clock, so an internal count freezes
		cpu_sleep <= 1'b1;
		restart(16'h8000);
		ticks(5);
		chk(OFS_COUNT, 16'h0000);
		cpu_sleep <= 1'b0;
	endtask : t_idle
	// ==========================================================
	// Main sequence
	initial begin
		{reset, reg_write, reg_read, cpu_idle, cpu_sleep, icc} = 6'h20;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_prescale();
		t_match();
		t_gate();
		t_ext();
		t_idle();
		report_and_stop();
	end
endmodule : tb_top
